//--- uuc_pkg.sv
// constants and carrier types for the universal up/down counter block
// assumes a single 100 MHz clock and an APB register slave in front of the counter

package uuc_pkg;

   // register byte addresses
   localparam logic [7:0] UUC_ADDR_CTRL = 8'h00;
   localparam logic [7:0] UUC_ADDR_PRESET = 8'h04;
   localparam logic [7:0] UUC_ADDR_STATUS = 8'h08;
   localparam logic [7:0] UUC_ADDR_RELOADS = 8'h0C;

   // control field positions
   localparam int UUC_CTRL_SEL_A = 0;
   localparam int UUC_CTRL_SEL_B = 1;
   localparam int UUC_CTRL_CIN_N = 2;
   localparam int UUC_CTRL_DIV_EN = 3;

   // status field positions
   localparam int UUC_STAT_CNT_LSB = 0;
   localparam int UUC_STAT_COUT_N = 4;
   localparam int UUC_STAT_DECADE = 5;

   // values after reset: hold mode, counting disabled, divider off
   localparam logic [3:0] UUC_CTRL_RST = 4'h7;
   localparam logic [3:0] UUC_PRESET_RST = 4'h0;
   localparam logic [3:0] UUC_COUNT_RST = 4'h0;

   // terminal counts
   localparam logic [3:0] UUC_HEX_MAX = 4'hF;
   localparam logic [3:0] UUC_DEC_MAX = 4'h9;

   // apb wait cycles inserted before pready
   localparam int UUC_APB_WAIT = 1;

   typedef enum logic [1:0] {
      UUC_OP_PRESET,
      UUC_OP_INC,
      UUC_OP_DEC,
      UUC_OP_HOLD
   } uuc_op_t;

   typedef struct packed {
      logic div_en;
      logic carry_in_n;
      logic mode_select_b;
      logic mode_select_a;
   } uuc_ctrl_t;

   typedef struct packed {
      logic [3:0] count;
      logic carry_out_n;
   } uuc_cnt_t;

endpackage

//--- uuc_core.sv
// four-bit synchronous universal counter core, hexadecimal or decade
// assumes operation and carry input come from logic on the same clock

`timescale 1ns/1ns

module uuc_core #(
   parameter bit DECADE = 1'b0
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // control
   input wire uuc_pkg::uuc_op_t op,
   input wire logic carry_in_n,
   input wire logic [3:0] preset_data,
   // state
   output uuc_pkg::uuc_cnt_t cnt
);
   import uuc_pkg::*;

   logic [3:0] count_r;
   logic [3:0] count_nxt;
   logic [3:0] top_val;
   logic [3:0] load_val;
   logic carry_out_n;

   assign top_val = DECADE ? UUC_DEC_MAX : UUC_HEX_MAX;
   // out-of-range preset saturates so a decade stage never holds above nine
   assign load_val = (preset_data > top_val) ? top_val : preset_data;

   always_comb begin
      carry_out_n = 1'b1;
      count_nxt = count_r;
      case (op)
         UUC_OP_PRESET: begin
            carry_out_n = 1'b0;
            count_nxt = load_val;
         end
         UUC_OP_INC: begin
            carry_out_n = carry_in_n | (count_r != top_val);
            if (!carry_in_n) begin
               count_nxt = (count_r == top_val) ? 4'h0 : 4'(count_r + 4'h1);
            end
         end
         UUC_OP_DEC: begin
            carry_out_n = carry_in_n | (count_r != 4'h0);
            if (!carry_in_n) begin
               count_nxt = (count_r == 4'h0) ? top_val : 4'(count_r - 4'h1);
            end
         end
         UUC_OP_HOLD: begin
            count_nxt = count_r;
         end
         default: begin
            count_nxt = count_r;
         end
      endcase
   end

   // state moves on the rising edge, or at once when resetn falls
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         count_r <= UUC_COUNT_RST;
      end else begin
         count_r <= count_nxt;
      end
   end

   // one driver for the whole carrier keeps the struct a single-source variable
   assign cnt = '{count: count_r, carry_out_n: carry_out_n};

   a_load_takes_data: assert property (
      @(posedge clk) disable iff (!resetn)
      op == UUC_OP_PRESET |=> count_r == $past(load_val))
      else $error("preset did not load data");

   a_cin_blocks_count: assert property (
      @(posedge clk) disable iff (!resetn)
      (op == UUC_OP_INC || op == UUC_OP_DEC) && carry_in_n |=> $stable(count_r))
      else $error("count moved while carry in high");

   a_range_limit: assert property (
      @(posedge clk) disable iff (!resetn)
      count_r <= top_val)
      else $error("count above terminal value");

   a_inc_wraps_zero: assert property (
      @(posedge clk) disable iff (!resetn)
      op == UUC_OP_INC && !carry_in_n && count_r == top_val |=> count_r == 4'h0)
      else $error("increment did not wrap");

   a_dec_terminal_carry: assert property (
      @(posedge clk) disable iff (!resetn)
      op == UUC_OP_DEC && !carry_in_n |-> carry_out_n == (count_r != 4'h0))
      else $error("decrement carry wrong");

   a_inc_terminal_carry: assert property (
      @(posedge clk) disable iff (!resetn)
      op == UUC_OP_INC && !carry_in_n |-> carry_out_n == (count_r != top_val))
      else $error("increment carry wrong");

   a_carry_or_cin: assert property (
      @(posedge clk) disable iff (!resetn)
      carry_in_n && op != UUC_OP_PRESET |-> carry_out_n)
      else $error("carry out low while carry in high");

   a_preset_forces_carry: assert property (
      @(posedge clk) disable iff (!resetn)
      op == UUC_OP_PRESET |-> !carry_out_n)
      else $error("preset did not force carry low");

endmodule

//--- uuc_top.sv
// universal up/down counter with self-reloading divider, apb register slave
// assumes an apb master on CLK; all counter control comes through registers
//
// The placing of the registers and the APB slave port were decided locally.

`timescale 1ns/1ns

module uuc_top #(
   parameter bit DECADE = 1'b0,
   parameter int RELOAD_W = 16
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RESETN,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic PREADY,
   output logic [31:0] PRDATA,
   output logic PSLVERR,
   // counter state
   output logic [3:0] COUNT,
   output logic CARRY_OUT_N
);
   import uuc_pkg::*;

   generate
      if (RELOAD_W < 1 || RELOAD_W > 32) begin : g_bad_width
         $error("RELOAD_W must be 1 to 32");
      end
   endgenerate

   uuc_ctrl_t ctrl_r;
   logic [3:0] preset_r;
   logic [RELOAD_W-1:0] reloads_r;
   logic pready_r;
   logic [31:0] prdata_r;
   logic pslverr_r;
   logic cout_r;
   logic [31:0] rd_data;
   logic addr_hit;
   logic acc;
   logic first_acc;
   logic wr_done;
   uuc_op_t op;
   logic core_cin_n;
   logic reload;
   uuc_cnt_t cnt;
   logic [3:0] top_val;
   logic [3:0] load_val;
   logic [4:0] gap_r;
   logic gap_valid_r;

   assign top_val = DECADE ? UUC_DEC_MAX : UUC_HEX_MAX;
   assign load_val = (preset_r > top_val) ? top_val : preset_r;

   // apb phases: one wait cycle so the answer comes from flip-flops
   assign acc = PSEL & PENABLE;
   assign first_acc = acc & ~pready_r;
   assign wr_done = acc & pready_r & PWRITE;

   always_comb begin
      addr_hit = 1'b1;
      rd_data = 32'h0000_0000;
      case (PADDR)
         UUC_ADDR_CTRL: begin
            rd_data[3:0] = ctrl_r;
         end
         UUC_ADDR_PRESET: begin
            rd_data[3:0] = preset_r;
         end
         UUC_ADDR_STATUS: begin
            rd_data[UUC_STAT_CNT_LSB +: 4] = cnt.count;
            rd_data[UUC_STAT_COUT_N] = cnt.carry_out_n;
            rd_data[UUC_STAT_DECADE] = DECADE;
         end
         UUC_ADDR_RELOADS: begin
            rd_data[RELOAD_W-1:0] = reloads_r;
         end
         default: begin
            addr_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         pready_r <= 1'b0;
      end else begin
         pready_r <= first_acc;
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         prdata_r <= 32'h0000_0000;
      end else if (first_acc) begin
         prdata_r <= PWRITE ? 32'h0000_0000 : rd_data;
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         pslverr_r <= 1'b0;
      end else begin
         pslverr_r <= first_acc & ~addr_hit;
      end
   end

   // control register steers the counter
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         ctrl_r <= UUC_CTRL_RST;
      end else if (wr_done && PADDR == UUC_ADDR_CTRL) begin
         ctrl_r <= PWDATA[3:0];
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         preset_r <= UUC_PRESET_RST;
      end else if (wr_done && PADDR == UUC_ADDR_PRESET) begin
         preset_r <= PWDATA[3:0];
      end
   end

   // select decode; in divider mode the feedback wiring is built in
   always_comb begin
      op = UUC_OP_HOLD;
      core_cin_n = ctrl_r.carry_in_n;
      if (ctrl_r.div_en) begin
         // zero detect rather than carry out avoids the preset lock-up
         core_cin_n = 1'b0;
         op = (cnt.count == 4'h0) ? UUC_OP_PRESET : UUC_OP_DEC;
      end else begin
         case ({ctrl_r.mode_select_a, ctrl_r.mode_select_b})
            2'b00: begin
               op = UUC_OP_PRESET;
            end
            2'b01: begin
               op = UUC_OP_INC;
            end
            2'b10: begin
               op = UUC_OP_DEC;
            end
            2'b11: begin
               op = UUC_OP_HOLD;
            end
            default: begin
               op = UUC_OP_HOLD;
            end
         endcase
      end
   end

   assign reload = ctrl_r.div_en & (cnt.count == 4'h0);

   uuc_core #(
      .DECADE(DECADE)
   ) u_core (
      .clk(CLK),
      .resetn(RESETN),
      .op(op),
      .carry_in_n(core_cin_n),
      .preset_data(preset_r),
      .cnt(cnt)
   );

   // reload tally; a reload in the clearing cycle still counts
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         reloads_r <= '0;
      end else if (wr_done && PADDR == UUC_ADDR_RELOADS) begin
         reloads_r <= reload ? RELOAD_W'(1) : '0;
      end else if (reload) begin
         reloads_r <= RELOAD_W'(reloads_r + RELOAD_W'(1));
      end
   end

   // carry output is registered, so it lags the counter state by one cycle
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         cout_r <= 1'b1;
      end else begin
         cout_r <= cnt.carry_out_n;
      end
   end

   assign PREADY = pready_r;
   assign PRDATA = prdata_r;
   assign PSLVERR = pslverr_r;
   assign COUNT = cnt.count;
   assign CARRY_OUT_N = cout_r;

   // helper: cycles between divider reloads
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         gap_r <= 5'h00;
      end else if (reload) begin
         gap_r <= 5'h01;
      end else if (gap_r != 5'h1F) begin
         gap_r <= 5'(gap_r + 5'h01);
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         gap_valid_r <= 1'b0;
      end else if (wr_done || !ctrl_r.div_en) begin
         gap_valid_r <= 1'b0;
      end else if (reload) begin
         gap_valid_r <= 1'b1;
      end
   end

   a_div_modulus: assert property (
      @(posedge CLK) disable iff (!RESETN)
      reload && gap_valid_r |-> gap_r == ({1'b0, load_val} + 5'h01))
      else $error("divider modulus not N plus one");

   a_div_reload_value: assert property (
      @(posedge CLK) disable iff (!RESETN)
      reload && !wr_done |=> cnt.count == $past(load_val))
      else $error("divider did not reload program value");

   a_div_no_lockup: assert property (
      @(posedge CLK) disable iff (!RESETN)
      ctrl_r.div_en && cnt.count != 4'h0 && !wr_done |=> cnt.count == $past(cnt.count) - 4'h1)
      else $error("divider stalled");

   a_select_decode: assert property (
      @(posedge CLK) disable iff (!RESETN)
      !ctrl_r.div_en && ctrl_r.mode_select_a && ctrl_r.mode_select_b |-> op == UUC_OP_HOLD)
      else $error("select code not hold");

   a_carry_pin_follows: assert property (
      @(posedge CLK) disable iff (!RESETN)
      1'b1 |=> CARRY_OUT_N == $past(cnt.carry_out_n))
      else $error("carry pin lag wrong");

   a_apb_one_wait: assert property (
      @(posedge CLK) disable iff (!RESETN)
      PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
      else $error("apb wait state wrong");

   a_apb_unmapped_err: assert property (
      @(posedge CLK) disable iff (!RESETN)
      first_acc && !addr_hit |=> PSLVERR && PREADY)
      else $error("unmapped access without error");

endmodule

//--- uuc_apb_master.sv
// apb master standing for the system logic that programs the counter
// assumes one clock; every apb request signal moves by non-blocking assignment just after a rising edge
`timescale 1ns/1ns

module uuc_apb_master (
   // clock
   input wire logic clk,
   // apb request
   output logic psel = 1'b0,
   output logic penable = 1'b0,
   output logic pwrite = 1'b0,
   output logic [7:0] paddr = 8'h00,
   output logic [31:0] pwdata = 32'h0,
   // apb answer
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr
);
   logic tmo = 1'b0;

   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] q, output logic e);
      q = 32'h0;
      e = 1'b0;
      tmo = 1'b1;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (int i = 0; i < 16; i++) begin
         @(posedge clk);
         if (pready === 1'b1) begin
            q = prdata;
            e = pslverr;
            tmo = 1'b0;
            break;
         end
      end
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines show a changed value so a stale address never looks valid
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule

//--- universal_updown_counter_tb.sv
// self-checking bench: hex and decade counters share one apb master
// assumes the counter answers every apb transfer within sixteen cycles
`timescale 1ns/1ns

module universal_updown_counter_tb;
   import uuc_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] cnt_h, cnt_d;
   logic cout_h, cout_d;
   logic [31:0] prdata_d;
   int err_count = 0;
   int compares = 0;

   always #5 clk = ~clk;

   uuc_apb_master m (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
   uuc_top #(.DECADE(1'b0), .RELOAD_W(16)) DUT (.CLK(clk), .RESETN(resetn), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready),
      .PRDATA(prdata), .PSLVERR(pslverr), .COUNT(cnt_h), .CARRY_OUT_N(cout_h));
   uuc_top #(.DECADE(1'b1), .RELOAD_W(16)) DUT_DEC (.CLK(clk), .RESETN(resetn), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(),
      .PRDATA(prdata_d), .PSLVERR(), .COUNT(cnt_d), .CARRY_OUT_N(cout_d));

   task automatic print_verdict();
      $display("counts: %0d compares, %0d mismatches", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk_cnt(input logic [4:0] got, input logic [4:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_reg(input logic [32:0] got, input logic [32:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [32:0] r);
      logic [31:0] q;
      logic e;
      m.xfer(w, a, d, q, e);
      r = {e, q};
      if (m.tmo) begin
         err_count++;
         $display("mismatch at %0t: no pready", $time);
         print_verdict();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [32:0] r;
      acc(1'b1, a, d, r);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [32:0] exp, input string what);
      logic [32:0] r;
      acc(1'b0, a, 32'h0, r);
      chk_reg(r, exp, what);
   endtask

   // next {carry_out_n, count} from the previous count; carry is registered one cycle late
   function automatic logic [4:0] nxt(input logic [3:0] c, input logic [3:0] ctl, input bit dec,
         input logic [3:0] pv);
      logic [3:0] mx;
      logic [3:0] ps;
      mx = dec ? UUC_DEC_MAX : UUC_HEX_MAX;
      ps = (pv > mx) ? mx : pv;
      if (ctl[3])
         return (c == 4'h0) ? {1'b0, ps} : {1'b1, c - 4'h1};
      case (ctl[1:0])
         2'b00: return {1'b0, ps};
         2'b10: return ctl[2] ? {1'b1, c} : {c != mx, (c == mx) ? 4'h0 : c + 4'h1};
         2'b01: return ctl[2] ? {1'b1, c} : {c != 4'h0, (c == 4'h0) ? mx : c - 4'h1};
         default: return {1'b1, c};
      endcase
   endfunction

   task automatic run(input logic [3:0] ctl, input logic [3:0] pv, input int n);
      logic [3:0] ph;
      logic [3:0] pd;
      wr(UUC_ADDR_CTRL, {28'h0, ctl});
      @(posedge clk);
      #1;
      ph = cnt_h;
      pd = cnt_d;
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         #1;
         chk_cnt({cout_h, cnt_h}, nxt(ph, ctl, 1'b0, pv), "hex count");
         chk_cnt({cout_d, cnt_d}, nxt(pd, ctl, 1'b1, pv), "decade count");
         ph = cnt_h;
         pd = cnt_d;
      end
      $display("test done: mode %h", ctl);
   endtask

   task automatic t_reset();
      chk_cnt({cout_h, cnt_h}, 5'h10, "reset hex");
      chk_cnt({cout_d, cnt_d}, 5'h10, "reset decade");
      rdc(UUC_ADDR_CTRL, 33'h0_0000_0007, "ctrl reset");
      rdc(UUC_ADDR_PRESET, 33'h0, "preset reset");
      rdc(UUC_ADDR_STATUS, 33'h0_0000_0010, "status reset");
      chk_reg({1'b0, prdata_d}, 33'h0_0000_0030, "status reset decade");
      rdc(8'h10, 33'h1_0000_0000, "unmapped");
      $display("test done: reset");
   endtask

   task automatic t_count();
      wr(UUC_ADDR_PRESET, 32'hC);
      run(4'h0, 4'hC, 3);
      run(4'h4, 4'hC, 3);
      run(4'h2, 4'hC, 20);
      run(4'h6, 4'hC, 4);
      run(4'h1, 4'hC, 20);
      run(4'h5, 4'hC, 4);
      run(4'h3, 4'hC, 4);
   endtask

   task automatic t_div();
      logic [3:0] pvs [3] = '{4'h0, 4'h9, 4'hF};
      // moduli 1, 10 and 16 cover both ends of the programmable range
      foreach (pvs[i]) begin
         wr(UUC_ADDR_PRESET, {28'h0, pvs[i]});
         run(4'h8, pvs[i], 20);
      end
   endtask

   task automatic t_regs();
      rdc(UUC_ADDR_PRESET, 33'h0_0000_000F, "preset readback");
      run(4'h3, 4'hF, 2);
      wr(UUC_ADDR_RELOADS, 32'h0);
      rdc(UUC_ADDR_RELOADS, 33'h0, "reloads cleared");
      wr(UUC_ADDR_STATUS, 32'hFFFF_FFFF);
      rdc(UUC_ADDR_CTRL, 33'h0_0000_0003, "ctrl after status write");
      $display("test done: registers");
   endtask

   initial begin
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      #1;
      t_reset();
      t_count();
      t_div();
      t_regs();
      print_verdict();
   end
endmodule
